/* inc/qcr_map.vh */
/*
 * qcr_map.vh: register offsets, field positions, query codes and reply
 * constants for the query command responder.
 * assumes: included by bare name, definitions only.
 */
`ifndef QCR_MAP_VH
`define QCR_MAP_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define QCR_ADDR_W 8
`define QCR_OFF_CMD 8'h00
`define QCR_OFF_RDATA 8'h04
`define QCR_OFF_ARM 8'h08
`define QCR_OFF_CTRL 8'h0C
`define QCR_OFF_STATUS 8'h10
`define QCR_OFF_SWITCH 8'h14

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define QCR_CMD_CODE_LSB 0
`define QCR_CMD_ARG_LSB 8
`define QCR_CTRL_NOTIFY_BIT 0
`define QCR_ARM_RST 8'h00
`define QCR_NOTIFY_RST 1'b0

// ----------------------------------------------------------------
// query codes written to the command register
// ----------------------------------------------------------------
`define QCR_Q_NAME 4'h0
`define QCR_Q_SER 4'h1
`define QCR_Q_VER 4'h2
`define QCR_Q_POS 4'h3
`define QCR_Q_TPOS 4'h4
`define QCR_Q_VEL 4'h5
`define QCR_Q_SPEED 4'h6
`define QCR_Q_PWM 4'h7
`define QCR_Q_CTRL_OUT 4'h8
`define QCR_Q_CUR_LIM 4'h9
`define QCR_Q_CUR 4'hA
`define QCR_Q_HEAT 4'hB
`define QCR_Q_ADV 4'hC
`define QCR_Q_STATUS 4'hD
`define QCR_Q_SWITCH 4'hE

// ----------------------------------------------------------------
// analog limits, counts at 1000 per volt
// ----------------------------------------------------------------
`define QCR_ADV_MAX 16'h2710
`define QCR_ADV_MIN 16'hD8F0

// ----------------------------------------------------------------
// ascii and axi answers
// ----------------------------------------------------------------
`define QCR_CH_CR 8'h0D
`define QCR_CH_LF 8'h0A
`define QCR_CH_MINUS 8'h2D
`define QCR_CH_ZERO 8'h30
`define QCR_CH_ERR 8'h72
`define QCR_RESP_OKAY 2'b00
`define QCR_RESP_SLVERR 2'b10

`endif

/* design/qcr_top.v */
/*
 * qcr_top: query command responder with an axi4-lite register slave.
 * software writes a query code, then pops the ascii reply byte by byte.
 * assumes: all inputs synchronous to sys_clk_i; values come from the
 * surrounding control loops already in their reported units.
 */
// What this block does
// (R1) name query replies controller designation string
// (R2) serial query replies unit serial number
// (R3) both velocity queries return target rpm
// (R4) pwm query returns voltage-mode commanded value
// (R5) controller output query returns applied output
// (R6) current limit query returns limit in mA
// (R7) measured current query returns actual mA
// (R8) heat query returns housing temperature celsius
// (R9) analog query returns input voltage, 1000/V
// (R10) input one signed, clamped to +-10000
// (R11) inputs three-five unsigned, clamped 0..10000
// (R12) host passes only inputs 1,3,4,5
// (R13) status bits 0-3 report homing/sequence activity
// (R14) status bits 4-7 report limit/error conditions
// (R15) status bits 8-12 mirror inputs; 13-15 reserved
// (R16) status bit 16 set at target position
// (R17) switch word bits 0-7 hold arm setting
// (R18) switch bits 24-31 latch triggered switches
// (R19) new setting clears all eight triggered flags
// (R20) failed command with notify replies "r"
// (R21) numeric replies are decimal ascii ending CR LF
`timescale 1ns/1ns
`include "qcr_map.vh"

module qcr_top #(
  parameter [63:0] NAME_STR = "QCR-0001",
  parameter [31:0] SERIAL_NUM = 32'h0000_0001,
  parameter [31:0] VERSION_NUM = 32'h0000_0064,
  parameter HAS_AIN45 = 1
) (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire [`QCR_ADDR_W-1:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output reg s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output reg s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [`QCR_ADDR_W-1:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output reg s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire [31:0] act_pos_i,
  input wire [31:0] tgt_pos_i,
  input wire [31:0] tgt_vel_i,
  input wire [31:0] pwm_cmd_i,
  input wire [31:0] ctrl_out_i,
  input wire [31:0] cur_lim_i,
  input wire [31:0] cur_act_i,
  input wire [31:0] heat_i,
  input wire [15:0] ain1_i,
  input wire [15:0] ain3_i,
  input wire [15:0] ain4_i,
  input wire [15:0] ain5_i,
  input wire homing_i,
  input wire seq_run_i,
  input wire seq_delay_i,
  input wire seq_notify_i,
  input wire cur_limiting_i,
  input wire dev_err_i,
  input wire over_volt_i,
  input wire over_temp_i,
  input wire [4:0] stat_in_i,
  input wire pos_reached_i,
  input wire [7:0] lim_sw_i,
  output reg notify_en_o
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function [31:0] clamp_s;
    input [15:0] v;
    begin
      if (!v[15] && v > `QCR_ADV_MAX) begin
        clamp_s = {16'h0000, `QCR_ADV_MAX};
      end else if (v[15] && v < `QCR_ADV_MIN) begin
        clamp_s = {16'hFFFF, `QCR_ADV_MIN};
      end else begin
        clamp_s = {{16{v[15]}}, v};
      end
    end
  endfunction

  function [31:0] clamp_u;
    input [15:0] v;
    begin
      clamp_u = {16'h0000, (v > `QCR_ADV_MAX) ? `QCR_ADV_MAX : v};
    end
  endfunction

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  reg rst_a_ff;
  reg rst_s_ff;
  wire rst_n;

  always @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_a_ff <= 1'b0;
      rst_s_ff <= 1'b0;
    end else begin
      rst_a_ff <= 1'b1;
      rst_s_ff <= rst_a_ff;
    end
  end
  assign rst_n = rst_s_ff;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_CONV = 1'b1;

  reg state_ff;
  reg aw_held_ff;
  reg w_held_ff;
  reg [`QCR_ADDR_W-1:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;
  reg go_ff;
  reg [3:0] code_ff;
  reg [2:0] arg_ff;
  reg [7:0] arm_ff;
  reg [7:0] trig_ff;
  reg [16:0] opstat_ff;
  reg [7:0] buf_ff [0:15];
  reg [31:0] mag_ff;
  reg neg_ff;
  reg [3:0] wr_idx_ff;
  reg [3:0] rd_idx_ff;
  reg avail_ff;
  integer i;

  wire do_wr = aw_held_ff & w_held_ff & ~s_axi_bvalid_o;
  wire [`QCR_ADDR_W-1:0] wa = {awaddr_ff[`QCR_ADDR_W-1:2], 2'b00};
  wire [`QCR_ADDR_W-1:0] ra = {s_axi_araddr_i[`QCR_ADDR_W-1:2], 2'b00};
  wire ar_go = s_axi_arvalid_i & s_axi_arready_o;
  wire busy = go_ff | (state_ff == ST_CONV);
  wire wr_cmd = do_wr & (wa == `QCR_OFF_CMD) & wstrb_ff[0] & ~busy;
  wire wr_arm = do_wr & (wa == `QCR_OFF_ARM) & wstrb_ff[0];
  wire wr_ctrl = do_wr & (wa == `QCR_OFF_CTRL) & wstrb_ff[0];
  wire wr_ok = (wa == `QCR_OFF_CMD) | (wa == `QCR_OFF_ARM) | (wa == `QCR_OFF_CTRL);
  wire pop = ar_go & (ra == `QCR_OFF_RDATA) & avail_ff;
  wire [31:0] switch_word = {trig_ff, 16'h0000, arm_ff}; // (R17)

  // divide by ten, one decimal digit per cycle
  wire [31:0] q10 = mag_ff / 32'd10;
  wire [31:0] q10x = {q10[28:0], 3'b000} + {q10[30:0], 1'b0};
  wire [31:0] rem10 = mag_ff - q10x;
  wire [7:0] dig = `QCR_CH_ZERO + {4'h0, rem10[3:0]};

  // ----------------------------------------------------------------
  // query value select
  // ----------------------------------------------------------------
  reg [31:0] qval;
  reg qerr;

  always @* begin
    qval = 32'h0000_0000;
    qerr = 1'b0;
    case (code_ff)
      `QCR_Q_NAME: qval = 32'h0000_0000;
      `QCR_Q_SER: qval = SERIAL_NUM; // (R2)
      `QCR_Q_VER: qval = VERSION_NUM;
      `QCR_Q_POS: qval = act_pos_i;
      `QCR_Q_TPOS: qval = tgt_pos_i;
      `QCR_Q_VEL: qval = tgt_vel_i; // (R3)
      `QCR_Q_SPEED: qval = tgt_vel_i; // (R3)
      `QCR_Q_PWM: qval = pwm_cmd_i; // (R4)
      `QCR_Q_CTRL_OUT: qval = ctrl_out_i; // (R5)
      `QCR_Q_CUR_LIM: qval = cur_lim_i; // (R6)
      `QCR_Q_CUR: qval = cur_act_i; // (R7)
      `QCR_Q_HEAT: qval = heat_i; // (R8)
      `QCR_Q_ADV: begin
        // (R9)
        case (arg_ff)
          3'd1: qval = clamp_s(ain1_i); // (R10)
          3'd3: qval = clamp_u(ain3_i); // (R11)
          3'd4: begin
            qval = clamp_u(ain4_i); // (R11)
            qerr = (HAS_AIN45 == 0); // (R12)
          end
          3'd5: begin
            qval = clamp_u(ain5_i); // (R11)
            qerr = (HAS_AIN45 == 0); // (R12)
          end
          default: qerr = 1'b1; // (R12)
        endcase
      end
      `QCR_Q_STATUS: qval = {15'h0000, opstat_ff};
      `QCR_Q_SWITCH: qval = switch_word;
      default: qerr = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // status words
  // ----------------------------------------------------------------
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      opstat_ff <= 17'h0_0000;
      trig_ff <= 8'h00;
      arm_ff <= `QCR_ARM_RST;
      notify_en_o <= `QCR_NOTIFY_RST;
    end else if (ce_i) begin
      opstat_ff[3:0] <= {seq_notify_i, seq_delay_i, seq_run_i, homing_i}; // (R13)
      opstat_ff[7:4] <= {over_temp_i, over_volt_i, dev_err_i, cur_limiting_i}; // (R14)
      opstat_ff[15:8] <= {3'b000, stat_in_i}; // (R15)
      opstat_ff[16] <= pos_reached_i; // (R16)
      // a switch that fires in the clearing cycle is kept: set wins
      trig_ff <= (trig_ff & ~{8{wr_arm}}) | (lim_sw_i & arm_ff); // (R18) (R19)
      if (wr_arm) begin
        arm_ff <= wdata_ff[7:0]; // (R17)
      end
      if (wr_ctrl) begin
        notify_en_o <= wdata_ff[`QCR_CTRL_NOTIFY_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite write and read channels
  // ----------------------------------------------------------------
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `QCR_RESP_OKAY;
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rresp_o <= `QCR_RESP_OKAY;
      s_axi_rdata_o <= 32'h0000_0000;
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= {`QCR_ADDR_W{1'b0}};
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else if (ce_i) begin
      s_axi_awready_o <= ~aw_held_ff & ~(s_axi_awvalid_i & s_axi_awready_o);
      s_axi_wready_o <= ~w_held_ff & ~(s_axi_wvalid_i & s_axi_wready_o);
      if (s_axi_awvalid_i & s_axi_awready_o) begin
        aw_held_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i & s_axi_wready_o) begin
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata_i;
        wstrb_ff <= s_axi_wstrb_i;
      end
      if (do_wr) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_ok ? `QCR_RESP_OKAY : `QCR_RESP_SLVERR;
      end else if (s_axi_bvalid_o & s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
      if (ar_go) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o <= `QCR_RESP_OKAY;
        case (ra)
          `QCR_OFF_CMD: s_axi_rdata_o <= {30'h0000_0000, avail_ff, busy};
          `QCR_OFF_RDATA: s_axi_rdata_o <= {23'h00_0000, avail_ff, buf_ff[rd_idx_ff]};
          `QCR_OFF_ARM: s_axi_rdata_o <= {24'h00_0000, arm_ff};
          `QCR_OFF_CTRL: s_axi_rdata_o <= {31'h0000_0000, notify_en_o};
          `QCR_OFF_STATUS: s_axi_rdata_o <= {15'h0000, opstat_ff};
          `QCR_OFF_SWITCH: s_axi_rdata_o <= switch_word;
          default: begin
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= `QCR_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid_o & s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end else if (~s_axi_rvalid_o) begin
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // reply builder: digits fill the buffer from the back
  // ----------------------------------------------------------------
  always @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      go_ff <= 1'b0;
      code_ff <= 4'h0;
      arg_ff <= 3'd0;
      mag_ff <= 32'h0000_0000;
      neg_ff <= 1'b0;
      wr_idx_ff <= 4'h0;
      rd_idx_ff <= 4'h0;
      avail_ff <= 1'b0;
      for (i = 0; i < 16; i = i + 1) begin
        buf_ff[i] <= 8'h00;
      end
    end else if (ce_i) begin
      go_ff <= wr_cmd;
      if (wr_cmd) begin
        // a new query discards any unread reply
        code_ff <= wdata_ff[`QCR_CMD_CODE_LSB +: 4];
        arg_ff <= wdata_ff[`QCR_CMD_ARG_LSB +: 3];
        avail_ff <= 1'b0;
      end else if (pop) begin
        rd_idx_ff <= rd_idx_ff + 4'h1;
        if (rd_idx_ff == 4'hF) begin
          avail_ff <= 1'b0;
        end
      end
      case (state_ff)
        ST_IDLE: begin
          if (go_ff) begin
            buf_ff[14] <= `QCR_CH_CR; // (R21)
            buf_ff[15] <= `QCR_CH_LF; // (R21)
            if (qerr) begin
              buf_ff[15] <= `QCR_CH_ERR; // (R20)
              rd_idx_ff <= 4'hF;
              avail_ff <= notify_en_o; // (R20)
            end else if (code_ff == `QCR_Q_NAME) begin
              for (i = 0; i < 8; i = i + 1) begin
                buf_ff[6 + i] <= NAME_STR[63 - 8 * i -: 8]; // (R1)
              end
              rd_idx_ff <= 4'h6;
              avail_ff <= 1'b1;
            end else begin
              neg_ff <= qval[31]; // (R21)
              mag_ff <= qval[31] ? (32'h0000_0000 - qval) : qval;
              wr_idx_ff <= 4'hD;
              state_ff <= ST_CONV;
            end
          end
        end
        ST_CONV: begin
          buf_ff[wr_idx_ff] <= dig; // (R21)
          mag_ff <= q10;
          wr_idx_ff <= wr_idx_ff - 4'h1;
          if (q10 == 32'h0000_0000) begin
            state_ff <= ST_IDLE;
            avail_ff <= 1'b1;
            if (neg_ff) begin
              buf_ff[wr_idx_ff - 4'h1] <= `QCR_CH_MINUS;
              rd_idx_ff <= wr_idx_ff - 4'h1;
            end else begin
              rd_idx_ff <= wr_idx_ff;
            end
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

endmodule

/* tb/qcr_chk.sv */
/* qcr_chk: bus and status assertions on the qcr_top ports.
   assumes: bound to qcr_top, ce_i held high, one clock domain. */
`timescale 1ns/1ns
`include "qcr_map.vh"
module qcr_chk (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire s_axi_awvalid_i,
  input wire s_axi_awready_o,
  input wire s_axi_wvalid_i,
  input wire s_axi_wready_o,
  input wire [1:0] s_axi_bresp_o,
  input wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [`QCR_ADDR_W-1:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  input wire s_axi_arready_o,
  input wire [31:0] s_axi_rdata_o,
  input wire [1:0] s_axi_rresp_o,
  input wire s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire homing_i,
  input wire seq_run_i,
  input wire seq_delay_i,
  input wire seq_notify_i,
  input wire cur_limiting_i,
  input wire dev_err_i,
  input wire over_volt_i,
  input wire over_temp_i,
  input wire [4:0] stat_in_i,
  input wire pos_reached_i
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire ar_hs = s_axi_arvalid_i && s_axi_arready_o;
  wire w_hs = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  wire [16:0] opstat = {pos_reached_i, 3'b000, stat_in_i, over_temp_i, over_volt_i,
    dev_err_i, cur_limiting_i, seq_notify_i, seq_delay_i, seq_run_i, homing_i};
  wr_answer_a: assert property (w_hs |-> ##2 s_axi_bvalid_o)
    else $error("write response late");
  rd_answer_a: assert property (ar_hs |=> s_axi_rvalid_o)
    else $error("read response late");
  b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data dropped");
  r_busy_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("address taken while read pending");
  // status is registered, so the word trails its inputs
  status_word_a: assert property (
    ar_hs && s_axi_araddr_i == `QCR_OFF_STATUS |=>
    s_axi_rdata_o == {15'h0000, $past(opstat, 2)}
    && s_axi_rresp_o == `QCR_RESP_OKAY) else $error("status word wrong");
  switch_gap_a: assert property (
    ar_hs && s_axi_araddr_i == `QCR_OFF_SWITCH |=> s_axi_rdata_o[23:8] == 16'h0000)
    else $error("switch word middle bits set");
  // the word of the last register spans four byte addresses
  bad_rd_a: assert property (ar_hs && s_axi_araddr_i > `QCR_OFF_SWITCH + 8'h03 |=>
    s_axi_rresp_o == `QCR_RESP_SLVERR && s_axi_rdata_o == 32'h0000_0000)
    else $error("unmapped read answered");
  cover property (w_hs);
  cover property (ar_hs && s_axi_araddr_i == `QCR_OFF_STATUS);
  cover property (ar_hs && s_axi_araddr_i > `QCR_OFF_SWITCH + 8'h03);
endmodule
bind qcr_top qcr_chk u_chk (.sys_clk_i, .rst_n_i, .s_axi_awvalid_i, .s_axi_awready_o,
  .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
  .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
  .s_axi_rvalid_o, .s_axi_rready_i, .homing_i, .seq_run_i, .seq_delay_i, .seq_notify_i,
  .cur_limiting_i, .dev_err_i, .over_volt_i, .over_temp_i, .stat_in_i, .pos_reached_i);

/* tb/qcr_host_bfm.sv */
/* qcr_host_bfm: host side, axi4-lite master issuing queries.
   assumes: one write and one read at most, answers sampled on posedge. */
`timescale 1ns/1ns
`include "qcr_map.vh"
module qcr_host_bfm (
  input wire clk_i,
  output logic [7:0] awaddr_o, output logic awvalid_o, input wire awready_i,
  output logic [31:0] wdata_o, output logic wvalid_o, input wire wready_i,
  input wire [1:0] bresp_i, input wire bvalid_i, output logic bready_o,
  output logic [7:0] araddr_o, output logic arvalid_o, input wire arready_i,
  input wire [31:0] rdata_i, input wire [1:0] rresp_i, input wire rvalid_i,
  output logic rready_o
);
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o} = '0;
  end
  // ----------------------------------------
  // bus cycles; negedge look equals posedge sample
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, da, dw;
    da = 0;
    dw = 0;
    @(posedge clk_i);
    awaddr_o <= a; awvalid_o <= 1; wdata_o <= d; wvalid_o <= 1; bready_o <= 1;
    while (!(da && dw)) begin
      @(negedge clk_i);
      ta = awvalid_o && awready_i;
      tw = wvalid_o && wready_i;
      @(posedge clk_i);
      if (ta) begin awvalid_o <= 0; da = 1; end
      if (tw) begin wvalid_o <= 0; dw = 1; end
    end
    do @(negedge clk_i); while (!bvalid_i);
    r = bresp_i;
    @(posedge clk_i);
    bready_o <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    araddr_o <= a; arvalid_o <= 1; rready_o <= 1;
    do @(negedge clk_i); while (!arready_i);
    @(posedge clk_i);
    arvalid_o <= 0;
    do @(negedge clk_i); while (!rvalid_i);
    d = rdata_i;
    r = rresp_i;
    @(posedge clk_i);
    rready_o <= 0;
  endtask
  // arg field carries the input number; caller sends 1,3,4,5, and 2 to get the error reply
endmodule

/* tb/test_query_command_responder.sv */
/* test_query_command_responder: query replies, status words, bus errors.
   assumes: qcr_top with default parameters, ce_i held high. */
`timescale 1ns/1ns
`include "qcr_map.vh"
module test_query_command_responder;
  logic clk = 0, rst_n = 0;
  logic [31:0] v [0:7];
  logic [15:0] ain [0:3];
  logic [7:0] sb = 8'h00, lsw = 8'h00;
  logic [4:0] sin = 5'h00;
  logic pr = 0;
  wire [7:0] awa, ara;
  wire [31:0] wd, rdt;
  wire [1:0] br, rr;
  wire awv, awr, wv, wr_, bv, bry, arv, arr, rv, rry, nen;
  int errors = 0, checked = 0, cyc = 0;
  logic [31:0] d;
  logic [1:0] r;
  initial forever #2 clk = ~clk;
  qcr_top dut (.sys_clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1), .s_axi_awaddr_i(awa),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_),
    .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_araddr_i(ara),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdt), .s_axi_rresp_o(rr),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .act_pos_i(v[0]), .tgt_pos_i(v[1]),
    .tgt_vel_i(v[2]), .pwm_cmd_i(v[3]), .ctrl_out_i(v[4]), .cur_lim_i(v[5]),
    .cur_act_i(v[6]), .heat_i(v[7]), .ain1_i(ain[0]), .ain3_i(ain[1]), .ain4_i(ain[2]),
    .ain5_i(ain[3]), .homing_i(sb[0]), .seq_run_i(sb[1]), .seq_delay_i(sb[2]),
    .seq_notify_i(sb[3]), .cur_limiting_i(sb[4]), .dev_err_i(sb[5]), .over_volt_i(sb[6]),
    .over_temp_i(sb[7]), .stat_in_i(sin), .pos_reached_i(pr), .lim_sw_i(lsw),
    .notify_en_o(nen));
  qcr_host_bfm host (.clk_i(clk), .awaddr_o(awa), .awvalid_o(awv), .awready_i(awr),
    .wdata_o(wd), .wvalid_o(wv), .wready_i(wr_), .bresp_i(br), .bvalid_i(bv),
    .bready_o(bry), .araddr_o(ara), .arvalid_o(arv), .arready_i(arr), .rdata_i(rdt),
    .rresp_i(rr), .rvalid_i(rv), .rready_o(rry));
  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      finish_test;
    end
  end
  // one query: empty text means no reply may appear
  task automatic q(input logic [3:0] c, input logic [2:0] a, input string s);
    int n;
    host.wr(`QCR_OFF_CMD, {21'h0, a, 4'h0, c}, r);
    n = 0;
    do begin
      host.rd(`QCR_OFF_CMD, d, r);
      n++;
    end while ((s.len() > 0 ? !d[1] : d[0]) && n < 200);
    if (s.len() == 0) chk(d[1:0], 2'b00);
    for (int i = 0; i < s.len(); i++) begin
      host.rd(`QCR_OFF_RDATA, d, r);
      chk(d[8:0], {1'b1, s[i]});
    end
    host.rd(`QCR_OFF_RDATA, d, r);
    chk(d[8], 1'b0);
  endtask
  function automatic string dec(input logic [31:0] x);
    return $sformatf("%0d\r\n", $signed(x));
  endfunction
  initial begin
    v[0] = 32'hFFFE_1DC0; v[1] = 32'h0000_3039; v[2] = 32'hFFFF_FC18; v[3] = 32'h0000_0000;
    v[4] = 32'h0000_7FFF; v[5] = 32'h0000_05DC; v[6] = 32'hFFFF_FFFF; v[7] = 32'h0000_002A;
    ain[0] = 16'hD120; ain[1] = 16'h3A98; ain[2] = 16'h04D2; ain[3] = 16'h0000;
    repeat (3) @(posedge clk);
    rst_n <= 1;
    sb <= 8'h55;
    sin <= 5'h16;
    pr <= 1;
    repeat (4) @(posedge clk);
    host.rd(`QCR_OFF_CTRL, d, r);
    chk(d[0], `QCR_NOTIFY_RST);
    chk(nen, `QCR_NOTIFY_RST);
    host.rd(`QCR_OFF_ARM, d, r);
    chk(d[7:0], `QCR_ARM_RST);
    q(`QCR_Q_NAME, 0, "QCR-0001\r\n");
    q(`QCR_Q_SER, 0, dec(32'h0000_0001));
    q(`QCR_Q_VER, 0, dec(32'h0000_0064));
    for (int k = 0; k < 8; k++)
      q(`QCR_Q_POS + k, 0, dec(v[k > 2 ? k - 1 : k]));
    q(`QCR_Q_CUR, 0, dec(v[6]));
    q(`QCR_Q_HEAT, 0, dec(v[7]));
    q(`QCR_Q_ADV, 1, "-10000\r\n");
    q(`QCR_Q_ADV, 3, "10000\r\n");
    q(`QCR_Q_ADV, 4, "1234\r\n");
    q(`QCR_Q_ADV, 5, "0\r\n");
    q(`QCR_Q_ADV, 2, "");
    host.wr(`QCR_OFF_CTRL, 32'h0000_0001, r);
    chk(r, `QCR_RESP_OKAY);
    chk(nen, 1'b1);
    q(`QCR_Q_ADV, 2, "r");
    q(4'hF, 0, "r");
    q(`QCR_Q_STATUS, 0, dec(32'h0001_1655));
    host.rd(`QCR_OFF_STATUS, d, r);
    chk(d, 32'h0001_1655);
    host.wr(`QCR_OFF_ARM, 32'h0000_0005, r);
    lsw <= 8'h0F;
    repeat (3) @(posedge clk);
    lsw <= 8'h00;
    host.rd(`QCR_OFF_SWITCH, d, r);
    chk(d, 32'h0500_0005);
    q(`QCR_Q_SWITCH, 0, dec(32'h0500_0005));
    host.wr(`QCR_OFF_ARM, 32'h0000_0005, r);
    host.rd(`QCR_OFF_SWITCH, d, r);
    chk(d, 32'h0000_0005);
    host.rd(8'h18, d, r);
    chk(r, `QCR_RESP_SLVERR);
    chk(d, 32'h0000_0000);
    host.wr(8'h1C, 32'h0000_0001, r);
    chk(r, `QCR_RESP_SLVERR);
    finish_test;
  end
endmodule
